/* core/cfw_sequencer.v */
// configuration word serial write sequencer, device side
// assumes programmer drives link clock and data, slower than CLK
`timescale 1ns/100ps
`include "cfw_consts.vh"
module cfw_sequencer (
  // clock and reset
  input  wire        CLK,
  input  wire        RST,
  // programming link
  input  wire        PGC,
  input  wire        PGD_IN,
  output reg         PGD_OUT,
  output reg         PGD_OE,
  // configuration word read port
  input  wire [2:0]  CFG_SEL,
  output reg  [7:0]  CFG_WORD,
  // status
  output reg         WRITE_BUSY,
  output reg  [15:0] TABLE_PAGE
);
  localparam WR_CYC = `CFW_WRITE_CYC;
  // one-word program code the start bit is checked against; bit 15 is
  // the start bit itself and is left out of the compare
  localparam [15:0] NVM_REQ = `CFW_NVM_ONE_WORD;
  // top nibble of a move-literal opcode sits in the upper half
  localparam [7:0]  MOVLIT  = `CFW_MOVLIT_TOP;

  reg         pgc_s1, pgc_s2;     // link clock synchroniser
  reg         pgd_s1, pgd_s2;     // link data synchroniser
  wire        exec_valid;         // a decoded instruction word
  wire [23:0] exec_word;          // its value
  wire        sh_out, sh_oe;      // shifter drive
  // only the working registers that the write sequence names exist;
  // moves to any other register are decoded as no-operations
  reg  [15:0] wreg_zero;          // working_reg_zero
  reg  [15:0] wreg_two;           // working_reg_two
  reg  [15:0] wreg_six;           // working_reg_six
  reg  [15:0] write_ptr;          // write_pointer_reg
  reg  [15:0] wreg_ten;           // working_reg_ten
  reg  [15:0] nvm_ctrl;           // nvm_control_register
  reg  [15:0] visi;               // visibility register
  reg  [7:0]  latch;              // single write latch
  reg  [15:0] latch_addr;         // address held with the latch
  // eight words; only the low byte of each word is kept
  reg  [7:0]  fuse [0:7];         // configuration words
  reg  [15:0] wcount;             // self timed write count
  reg  [15:0] pc;                 // internal program counter
  integer     i;

  // default value of a configuration word by index
  function [7:0] def_word;
    input [2:0] idx;
    begin
      case (idx)
        3'h0:    def_word = `CFW_DEF_BOOT;
        3'h1:    def_word = `CFW_DEF_GEN;
        3'h2:    def_word = `CFW_DEF_OSCSEL;
        3'h3:    def_word = `CFW_DEF_OSC;
        3'h4:    def_word = `CFW_DEF_WDT;
        3'h5:    def_word = `CFW_DEF_POR;
        3'h6:    def_word = `CFW_DEF_DEBUG;
        default: def_word = `CFW_DEF_DSLEEP;
      endcase
    end
  endfunction

  // true when word is a move-literal to the given register
  function is_movlit;
    input [23:0] w;
    input [3:0]  rd;
    begin
      // 2kkkkd: opcode nibble on top, destination in the low nibble
      is_movlit = (w[23:20] == MOVLIT[7:4]) && (w[3:0] == rd);
    end
  endfunction

  // the programmer's clock is unrelated to CLK, so both pins come
  // in through two flops before any edge is looked for
  // two flops on each pin; only the second is read
  always @(posedge CLK) begin
    if (RST) begin
      pgc_s1 <= 1'b0;
      pgc_s2 <= 1'b0;
      pgd_s1 <= 1'b0;
      pgd_s2 <= 1'b0;
    end else begin
      pgc_s1 <= PGC;
      pgc_s2 <= pgc_s1;
      pgd_s1 <= PGD_IN;
      pgd_s2 <= pgd_s1;
    end
  end

  // shifter finds link clock edges and frames codes and words; it
  // samples data on the rising edge and changes output after the fall
  cfw_shifter u_shift (
    .clk        (CLK),
    .rst        (RST),
    .pgc        (pgc_s2),
    .pgd_in     (pgd_s2),
    .out_word   (visi),
    .exec_valid (exec_valid),
    .exec_word  (exec_word),
    .pgd_out    (sh_out),
    .pgd_oe     (sh_oe)
  );

  // instruction execution and self timed write
  // only the opcodes that the configuration write sequence uses are
  // decoded; any other word just advances the counter, so extra
  // instructions from the programmer do no harm
  always @(posedge CLK) begin
    if (RST) begin
      // working registers and control start cleared
      wreg_zero  <= 16'h0000;
      wreg_two   <= 16'h0000;
      wreg_six   <= 16'h0000;
      write_ptr  <= 16'h0000;
      wreg_ten   <= 16'h0000;
      nvm_ctrl   <= 16'h0000;
      visi       <= 16'h0000;
      latch      <= 8'hFF;
      latch_addr <= 16'h0000;
      wcount     <= 16'h0000;
      pc         <= 16'h0000;
      TABLE_PAGE <= 16'h0000;
      // words go back to their defaults
      for (i = 0; i < `CFW_NUM_WORDS; i = i + 1)
        fuse[i] <= def_word(i[2:0]);
    end else begin
      // write timer: hardware clears the start bit at the end
      // the array takes the latch only here, so a latch reloaded while
      // a write runs is committed when that running write ends
      if (nvm_ctrl[`CFW_WR_BIT]) begin
        if (wcount == WR_CYC[15:0] - 16'h0001) begin
          // last cycle: commit the word and drop the start bit
          wcount <= 16'h0000;
          nvm_ctrl[`CFW_WR_BIT] <= 1'b0;
          fuse[latch_addr[3:1]] <= latch;
        end else begin
          // still programming
          wcount <= wcount + 16'h0001;
        end
      end
      // a decoded word; it is assigned after the timer, so a start in
      // the timer's last cycle wins over the hardware clear
      if (exec_valid) begin
        // counter moves one instruction per frame
        pc <= pc + 16'h0002;
        // jump back to the top of the sequence
        if (exec_word == `CFW_OP_GOTO_RST)
          pc <= 16'h0200;
        // literal into working_reg_zero, the page source
        else if (is_movlit(exec_word, 4'h0))
          wreg_zero <= exec_word[19:4];
        // literal into working_reg_six, the data holder
        else if (is_movlit(exec_word, 4'h6))
          wreg_six <= exec_word[19:4];
        // literal into the write pointer
        else if (is_movlit(exec_word, 4'h7))
          write_ptr <= exec_word[19:4];
        // literal into working_reg_ten, the control source
        else if (is_movlit(exec_word, 4'hA))
          wreg_ten <= exec_word[19:4];
        // control load is refused while a write runs
        else if (exec_word == `CFW_OP_MOVW10_NVM &&
                 !nvm_ctrl[`CFW_WR_BIT])
          nvm_ctrl <= wreg_ten;
        // page register takes working_reg_zero
        else if (exec_word == `CFW_OP_MOV_W0_PAGE)
          TABLE_PAGE <= wreg_zero;
        // table write: one latch, pointer moves on by one word
        else if (exec_word == `CFW_OP_TABLE_WRITE_LOW_W6 ||
                 exec_word == `CFW_OP_TABLE_WRITE_LOW_W0) begin
          latch      <= (exec_word[3:0] == 4'h6) ? wreg_six[7:0]
                                                 : wreg_zero[7:0];
          latch_addr <= write_ptr;
          write_ptr  <= write_ptr + 16'h0002;
        // start only with the one-word code in the control register
        end else if (exec_word == `CFW_OP_BIT_SET_INSTRUCTION_WR &&
                     nvm_ctrl[14:0] == NVM_REQ[14:0])
          nvm_ctrl[`CFW_WR_BIT] <= 1'b1;
        // control register copied for polling
        else if (exec_word == `CFW_OP_MOV_NVM_W2)
          wreg_two <= nvm_ctrl;
        // working_reg_two shown to the programmer
        else if (exec_word == `CFW_OP_MOV_W2_VISI)
          visi <= wreg_two;
      end
    end
  end

  // registered outputs
  // each output leaves from a flop, so the pins see no decode glitch
  always @(posedge CLK) begin
    if (RST) begin
      PGD_OUT    <= 1'b0;
      PGD_OE     <= 1'b0;
      CFG_WORD   <= 8'h00;
      WRITE_BUSY <= 1'b0;
    end else begin
      // link drive trails the shifter by one cycle
      PGD_OUT    <= sh_out;
      PGD_OE     <= sh_oe;
      CFG_WORD   <= fuse[CFG_SEL];
      WRITE_BUSY <= nvm_ctrl[`CFW_WR_BIT];
    end
  end
endmodule // cfw_sequencer

/* core/cfw_consts.vh */
// constants for the configuration word serial write sequencer
// assumes inclusion by bare name from core design files
`ifndef CFW_CONSTS_VH
`define CFW_CONSTS_VH
// command codes, four bits, shifted lsb first
`define CFW_CMD_EXEC       4'h0
`define CFW_CMD_REGISTER_OUTPUT_COMMAND     4'h1
// instruction opcodes recognised by the sequencer
`define CFW_OP_NOP         24'h000000
`define CFW_OP_GOTO_RST    24'h040200
`define CFW_OP_MOVW10_NVM  24'h883B0A
`define CFW_OP_MOV_W0_PAGE 24'h880190
`define CFW_OP_TABLE_WRITE_LOW_W6   24'hBB1B86
`define CFW_OP_TABLE_WRITE_LOW_W0   24'hBB1B80
`define CFW_OP_BIT_SET_INSTRUCTION_WR     24'hA8E761
`define CFW_OP_MOV_NVM_W2  24'h803B02
`define CFW_OP_MOV_W2_VISI 24'h883C22
// field positions
`define CFW_WR_BIT         15
`define CFW_MOVLIT_TOP     8'h20
// write op code in the nvm control register
`define CFW_NVM_ONE_WORD   16'h4004
// number of configuration words
`define CFW_NUM_WORDS      8
// default values of the configuration words, index order
`define CFW_DEF_BOOT       8'h0F
`define CFW_DEF_GEN        8'h03
`define CFW_DEF_OSCSEL     8'h87
`define CFW_DEF_OSC        8'hFF
`define CFW_DEF_WDT        8'hDF
`define CFW_DEF_POR        8'hFB
`define CFW_DEF_DEBUG      8'hC3
`define CFW_DEF_DSLEEP     8'hFF
// self timed write length
`define CFW_WRITE_NS       2000
`define CFW_CLK_MHZ        50
`define CFW_WRITE_CYC      ((`CFW_WRITE_NS * `CFW_CLK_MHZ) / 1000)
`endif

/* core/cfw_shifter.v */
// serial shifter for the two wire programming port
// assumes link clock and data already synchronised to CLK
`timescale 1ns/100ps
module cfw_shifter (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // synchronised link pins
  input  wire        pgc,
  input  wire        pgd_in,
  // word to send on a register output command
  input  wire [15:0] out_word,
  // decoded frames
  output reg         exec_valid,
  output reg  [23:0] exec_word,
  output reg         pgd_out,
  output reg         pgd_oe
);
  localparam S_CMD  = 3'b001; // collecting 4 bit code
  localparam S_DATA = 3'b010; // collecting 24 bit word
  localparam S_OUT  = 3'b100; // driving 16 bits out

  reg  [2:0]  state;       // one-hot state
  reg  [4:0]  count;       // bits seen in this phase
  reg  [23:0] shreg;       // incoming shift register
  reg  [15:0] oreg;        // outgoing shift register
  reg         pgc_d;       // delayed clock for edge find
  wire        rise = pgc & ~pgc_d;
  wire        fall = ~pgc & pgc_d;

  // edge detect, shifting lsb first, code then payload
  always @(posedge clk) begin
    if (rst) begin
      state      <= S_CMD;
      count      <= 5'h00;
      shreg      <= 24'h000000;
      oreg       <= 16'h0000;
      pgc_d      <= 1'b0;
      exec_valid <= 1'b0;
      exec_word  <= 24'h000000;
      pgd_out    <= 1'b0;
      pgd_oe     <= 1'b0;
    end else begin
      pgc_d      <= pgc;
      exec_valid <= 1'b0;
      case (state)
        S_CMD: if (rise) begin
          // lsb first: new bit enters at the top
          shreg <= {pgd_in, shreg[23:1]};
          if (count == 5'h03) begin
            count <= 5'h00;
            if ({pgd_in, shreg[23:21]} == `CFW_CMD_REGISTER_OUTPUT_COMMAND) begin
              state  <= S_OUT;
              oreg   <= out_word;
              pgd_oe <= 1'b1;
            end else begin
              // unknown codes are treated as execute
              state <= S_DATA;
            end
          end else begin
            count <= count + 5'h01;
          end
        end
        S_DATA: if (rise) begin
          shreg <= {pgd_in, shreg[23:1]};
          if (count == 5'h17) begin
            count      <= 5'h00;
            state      <= S_CMD;
            exec_valid <= 1'b1;
            exec_word  <= {pgd_in, shreg[23:1]};
          end else begin
            count <= count + 5'h01;
          end
        end
        S_OUT: begin
          // data changes on the falling edge, read just before the next fall
          if (fall) begin
            pgd_out <= oreg[0];
            oreg    <= {1'b0, oreg[15:1]};
          end
          if (rise) begin
            if (count == 5'h0F) begin
              count <= 5'h00;
              state <= S_CMD;
            end else begin
              count <= count + 5'h01;
            end
          end
          if (state == S_OUT && rise && count == 5'h0F)
            pgd_oe <= 1'b0;
        end
        default: state <= S_CMD;
      endcase
    end
  end
endmodule // cfw_shifter

/* tb/cfw_props.sv */
// checker for the config word write sequencer ports
// assumes binding into cfw_sequencer, consts header on path
`timescale 1ns/100ps
`include "cfw_consts.vh"
module cfw_props (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RST,
  // link and status
  input wire logic        PGC,
  input wire logic        PGD_OUT,
  input wire logic        PGD_OE,
  input wire logic        WRITE_BUSY,
  input wire logic [15:0] TABLE_PAGE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  logic [7:0] busy_cnt; // cycles the write has run
  logic [7:0] oe_cnt;   // cycles the pin was driven
  // counters restart when their signal drops
  always @(posedge CLK) begin
    busy_cnt <= (RST || !WRITE_BUSY) ? 8'h00 : busy_cnt + 8'h01;
    oe_cnt   <= (RST || !PGD_OE) ? 8'h00 : oe_cnt + 8'h01;
  end
  sequence busy_run; WRITE_BUSY [*8]; endsequence
  sequence oe_run; PGD_OE [*8]; endsequence
  reset_clear_a: assert property (disable iff (1'b0) RST |=>
    !WRITE_BUSY && !PGD_OE && TABLE_PAGE == 16'h0000) else $error("reset");
  busy_hold_a: assert property ($rose(WRITE_BUSY) |=> busy_run)
    else $error("busy short");
  busy_len_a: assert property ($fell(WRITE_BUSY) |-> busy_cnt inside
    {[`CFW_WRITE_CYC-1:`CFW_WRITE_CYC+1]}) else $error("write length");
  busy_quiet_a: assert property ($rose(WRITE_BUSY) |-> !PGD_OE)
    else $error("write during output");
  oe_hold_a: assert property ($rose(PGD_OE) |=> oe_run)
    else $error("output short");
  oe_len_a: assert property (oe_cnt <= 8'h96)
    else $error("output long");
  out_edge_a: assert property (PGD_OE && $past(PGD_OE) &&
    $changed(PGD_OUT) |-> !$past(PGC, 2)) else $error("bit edge");
  page_quiet_a: assert property (PGD_OE |=> $stable(TABLE_PAGE))
    else $error("page moved");
endmodule // cfw_props
bind cfw_sequencer cfw_props u_props (.CLK(CLK), .RST(RST), .PGC(PGC),
  .PGD_OUT(PGD_OUT), .PGD_OE(PGD_OE), .WRITE_BUSY(WRITE_BUSY),
  .TABLE_PAGE(TABLE_PAGE));

/* tb/cfw_prog_model.sv */
// programmer model for the two wire programming link
// assumes pgd is the resolved data wire, clk the bench clock
`timescale 1ns/100ps
module cfw_prog_model (
  // bench clock and resolved data
  input  wire logic clk,
  input  wire logic pgd,
  // link drive
  output logic      pgc,
  output logic      pgd_drv
);
  initial pgc = 1'b0; // link clock idles low
  initial pgd_drv = 1'b0;
  // half link period, four bench clocks
  task automatic half;
    repeat (4) @(posedge clk);
  endtask
  // data set up a half period before the rise
  task automatic bitout(input logic b);
    pgd_drv <= b;
    half;
    pgc <= 1'b1;
    half;
    pgc <= 1'b0;
  endtask
  // execute frame, code then word, lsb first
  task automatic ex(input logic [23:0] w);
    logic [27:0] f;
    f = {w, 4'h0};
    for (int i = 0; i < 28; i++) bitout(f[i]);
  endtask
  // output frame, sampled just before each fall
  task automatic register_output_command(output logic [15:0] v);
    for (int i = 0; i < 4; i++) bitout(i == 0);
    pgd_drv <= ~pgd_drv;
    for (int i = 0; i < 16; i++) begin
      half;
      pgc <= 1'b1;
      half;
      v[i] = pgd;
      pgc <= 1'b0;
    end
    half;
  endtask
  // one word: exit reset, set up, latch, start, bounded poll
  task automatic program_word(input logic [2:0] idx,
                              input logic [7:0] val,
                              output logic [15:0] v);
    logic [23:0] s [16];
    logic [23:0] p [5];
    s = '{24'h000000, 24'h040200, 24'h000000,
      {4'h2, 12'h000, idx, 1'b0, 4'h7},
      24'h24004A, 24'h883B0A,
      24'h200F80, 24'h880190,
      {4'h2, 8'h00, val, 4'h6},
      24'h000000, 24'hBB1B86, 24'h000000, 24'h000000,
      24'hA8E761, 24'h000000, 24'h000000};
    p = '{24'h040200, 24'h000000, 24'h803B02, 24'h883C22, 24'h000000};
    v = 16'h8000;
    foreach (s[i]) ex(s[i]);
    for (int k = 0; k < 10 && v[15]; k++) begin
      foreach (p[i]) ex(p[i]);
      register_output_command(v);
      ex(24'h000000);
    end
    ex(24'h040200);
    ex(24'h000000);
  endtask
endmodule // cfw_prog_model

/* tb/config_fuse_serial_write_tb.sv */
// self-checking bench for the config word write sequencer
// assumes model and checker files compiled beforehand
`timescale 1ns/100ps
module config_fuse_serial_write_tb;
  logic        clk = 1'b0; // 50 MHz bench clock
  logic        rst = 1'b1; // synchronous reset
  logic [2:0]  sel = 3'h0; // word select
  logic        pgc;        // link clock from model
  logic        pgd_drv;    // model data drive
  logic        pgd_out;
  logic        pgd_oe;
  logic [7:0]  word;
  logic        busy;
  logic [15:0] page;
  logic [15:0] vis;        // value read over the link
  logic [7:0]  got;
  logic [7:0]  exp_w [8];  // values written
  int          n_mismatch = 0;
  int          n_tests = 0;
  wire         pgd = pgd_oe ? pgd_out : pgd_drv; // resolved wire
  always #10 clk = ~clk;
  cfw_sequencer dut (.CLK(clk), .RST(rst), .PGC(pgc), .PGD_IN(pgd),
    .PGD_OUT(pgd_out), .PGD_OE(pgd_oe), .CFG_SEL(sel), .CFG_WORD(word),
    .WRITE_BUSY(busy), .TABLE_PAGE(page));
  cfw_prog_model m (.clk(clk), .pgd(pgd), .pgc(pgc), .pgd_drv(pgd_drv));
  // word values straight after reset
  function automatic logic [7:0] dflt(input logic [2:0] i);
    case (i)
      3'h0: return 8'h0F;
      3'h1: return 8'h03;
      3'h2: return 8'h87;
      3'h4: return 8'hDF;
      3'h5: return 8'hFB;
      3'h6: return 8'hC3;
      default: return 8'hFF;
    endcase
  endfunction
  // compare and count, report mismatches only
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // select a word, read it once settled
  task automatic rd(input logic [2:0] i, output logic [7:0] w);
    @(posedge clk);
    sel <= i;
    @(negedge clk);
    @(negedge clk);
    w = word;
  endtask
  task automatic results;
    if (n_mismatch == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // main sequence
  initial begin
    void'($urandom(32'h792da180));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(i[2:0], got);
      chk("default", {8'h00, dflt(i[2:0])}, {8'h00, got});
    end
    for (int i = 0; i < 8; i++) begin
      exp_w[i] = 8'($urandom);
      if (i == 5) exp_w[i][4] = 1'b1;
      if (i == 6) exp_w[i][6] = 1'b1;
      @(posedge clk);
      m.program_word(i[2:0], exp_w[i], vis);
      chk("status", 16'h4004, vis);
      chk("page", 16'h00F8, page);
    end
    for (int i = 0; i < 8; i++) begin
      rd(i[2:0], got);
      chk("word", {8'h00, exp_w[i]}, {8'h00, got});
    end
    results;
  end
  // hang guard, well past the expected run length
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    results;
  end
endmodule // config_fuse_serial_write_tb
